/* verilog/emp_port.sv */
// external memory port pin logic: address, data, attribute/row strobes, bus clock
// assumes arbitration supplies bus ownership; core supplies accesses and pll settings
`timescale 1ns/10ps
`include "emp_defines.svh"
module emp_port import emp_pkg::*; #(
  parameter int ADDR_W = `EMP_ADDR_W,
  parameter int DATA_W = `EMP_DATA_W,
  parameter int ATTR_N = `EMP_ATTR_N
) (
  input wire logic mclk_i, // core clock 40 mhz
  input wire logic rst_n_i, // async reset, low
  input wire logic bus_owner_i, // granted by arbiter
  input wire logic standby_i, // stop or wait mode
  input wire logic pll_en_i, // pll enabled
  input wire logic pll_unity_i, // mf and df equal one
  input wire logic ref_clock_in_i, // reference clock pin
  input wire logic acc_req_i, // core access request pulse
  input wire logic acc_wr_i, // 1 write, 0 read
  input wire logic [ADDR_W-1:0] acc_addr_i, // access address
  input wire logic [DATA_W-1:0] acc_wdata_i, // write data
  input wire logic [ATTR_N-1:0] attr_sel_i, // attribute lines to assert
  input wire logic [ATTR_N-1:0] attr_ras_mode_i, // 1 row strobe, 0 attribute
  input wire logic [ATTR_N-1:0] attr_pol_i, // 1 active high
  input wire logic transfer_ack_in_i, // ack pin, low active
  input wire logic [DATA_W-1:0] ext_data_in_i, // data pins in
  output logic [ADDR_W-1:0] ext_addr_out_o, // address pins
  output logic ext_addr_oe_n_o, // address enable, low drives
  output logic [DATA_W-1:0] ext_data_out_o, // data pins out
  output logic ext_data_oe_n_o, // data enable, low drives
  output logic [ATTR_N-1:0] addr_attribute_lines_o, // attribute/row strobe pins
  output logic attr_oe_n_o, // attribute enable, low drives
  output logic bus_clock_out_o, // output clock
  output logic acc_done_o, // access complete pulse
  output logic [DATA_W-1:0] acc_rdata_o // read data
);
  emp_state_e st, next_st;
  logic [ADDR_W-1:0] addr, next_addr;
  logic [DATA_W-1:0] wdata, next_wdata, rdata, next_rdata;
  logic [ATTR_N-1:0] attr, next_attr;
  logic wr, next_wr, done, next_done, drv, next_drv, ddrv, next_ddrv;
  logic clk_q, next_clk_q, ack_seen, next_ack_seen;
  logic ack_hi, next_ack_hi;
  logic ref_lvl, ref_rise, ack_lvl;
  logic own;

  emp_sync u_ref (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(ref_clock_in_i),
    .sync_o(ref_lvl),
    .rise_o(ref_rise),
    .fall_o()
  );
  emp_sync u_ack (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(transfer_ack_in_i),
    .sync_o(ack_lvl),
    .rise_o(),
    .fall_o()
  );

  // ownership gate; standby forces release
  assign own = bus_owner_i & ~standby_i;

  // access sequencer and pin drive
  always_comb begin
    next_st = st;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_wr = wr;
    next_attr = attr;
    next_done = 1'b0;
    next_ack_seen = ack_seen;
    next_ack_hi = ack_hi;
    case (st)
      EMP_IDLE: begin
        next_attr = ~attr_pol_i; // deasserted level per polarity
        if (acc_req_i && own) begin
          next_st = EMP_BUSY;
          next_addr = acc_addr_i;
          next_wdata = acc_wdata_i;
          next_wr = acc_wr_i;
          next_ack_seen = 1'b0;
          next_ack_hi = 1'b0;
          // attribute or row strobe asserted at chosen polarity
          next_attr = (attr_sel_i & attr_pol_i) | (~attr_sel_i & ~attr_pol_i);
        end
      end
      EMP_BUSY: begin
        // a stale ack left from the last access lags through the synchroniser;
        // only an ack seen released during this access may count
        next_ack_hi = ack_hi | ack_lvl;
        // ack sampled on bus clock rise; finish one period later
        if (ref_rise_bus() && ack_seen) begin
          next_st = EMP_DONE;
          next_rdata = ext_data_in_i;
        end else if (ref_rise_bus() && !ack_lvl && ack_hi) begin
          next_ack_seen = 1'b1;
        end
        if (!own) begin
          next_st = EMP_IDLE;
        end
      end
      EMP_DONE: begin
        next_done = 1'b1;
        next_attr = ~attr_pol_i;
        next_st = EMP_IDLE;
      end
      default: next_st = EMP_IDLE;
    endcase
    next_drv = own;
    next_ddrv = own && wr && (st == EMP_BUSY) && (next_st == EMP_BUSY);
  end

  // bus clock rise: core phase with pll on and not unity, reference level rise with unity pll, every second reference rise without pll
  function automatic logic ref_rise_bus();
    ref_rise_bus = next_clk_q & ~clk_q;
  endfunction

  // output clock: toggle per core cycle with pll unless unity (then follows reference level), per reference rise without
  always_comb begin
    if (pll_en_i) begin
      next_clk_q = pll_unity_i ? ref_lvl : ~clk_q;
    end else begin
      next_clk_q = ref_rise ? ~clk_q : clk_q; // half reference
    end
  end
  // bus clock is held to at most half the core rate; 20 mhz stays below the limit

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= EMP_IDLE;
      addr <= ADDR_W'(`EMP_ADDR_RST);
      wdata <= DATA_W'(`EMP_DATA_RST);
      rdata <= DATA_W'(`EMP_DATA_RST);
      wr <= 1'b0;
      attr <= '0;
      done <= 1'b0;
      drv <= 1'b0;
      ddrv <= 1'b0;
      clk_q <= 1'b0;
      ack_seen <= 1'b0;
      ack_hi <= 1'b0;
    end else begin
      st <= next_st;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      wr <= next_wr;
      attr <= next_attr;
      done <= next_done;
      drv <= next_drv;
      ddrv <= next_ddrv;
      clk_q <= next_clk_q;
      ack_seen <= next_ack_seen;
      ack_hi <= next_ack_hi;
    end
  end

  assign ext_addr_out_o = addr;
  assign ext_addr_oe_n_o = ~drv;
  assign ext_data_out_o = wdata;
  assign ext_data_oe_n_o = ~ddrv;
  assign addr_attribute_lines_o = attr;
  assign attr_oe_n_o = ~drv;
  assign bus_clock_out_o = clk_q;
  assign acc_done_o = done;
  assign acc_rdata_o = rdata;

  // checks
  AST_STANDBY_FLOAT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    standby_i |=> ext_addr_oe_n_o && ext_data_oe_n_o && attr_oe_n_o)
    else $error("port driven in standby");
  AST_OWN_DRIVE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (bus_owner_i && !standby_i) |=> !ext_addr_oe_n_o)
    else $error("address not driven while owner");
  AST_ADDR_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st == EMP_IDLE && !acc_req_i) |=> $stable(ext_addr_out_o))
    else $error("address toggled while idle");
  AST_DATA_OWN: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !ext_data_oe_n_o |-> $past(bus_owner_i))
    else $error("data driven without ownership");
  AST_ATTR_POL: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st == EMP_IDLE && $past(st) == EMP_IDLE) |-> attr == ~$past(attr_pol_i))
    else $error("attribute idle level wrong");
  AST_ATTR_ASSERT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st == EMP_IDLE && acc_req_i && own) |=>
    attr == (($past(attr_sel_i) & $past(attr_pol_i)) |
    (~$past(attr_sel_i) & ~$past(attr_pol_i))))
    else $error("attribute strobe level wrong");
  AST_RAS_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st == EMP_BUSY && $past(st) == EMP_BUSY) |->
    ((attr ^ $past(attr)) & attr_ras_mode_i) == '0)
    else $error("row strobe moved during access");
  AST_HALF_REF: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!pll_en_i && ref_rise) |=> bus_clock_out_o != $past(bus_clock_out_o))
    else $error("bus clock missed reference edge");
  AST_CORE_PHASE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (pll_en_i && !pll_unity_i) |=> bus_clock_out_o != $past(bus_clock_out_o))
    else $error("bus clock not at core phase");
  AST_ACK_DONE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st == EMP_DONE) |=> acc_done_o && st == EMP_IDLE)
    else $error("done pulse missing");
  AST_DONE_ON_RISE: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(st == EMP_DONE) |-> $rose(bus_clock_out_o))
    else $error("cycle ended off a bus clock rise");
  COV_ABORT: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    st == EMP_BUSY ##1 (st == EMP_IDLE && !acc_done_o));
  COV_READ: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    acc_done_o && !wr);
  COV_WRITE: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    acc_done_o && wr);
  COV_STANDBY: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    st == EMP_BUSY ##1 standby_i);
endmodule

/* common/emp_defines.svh */
// external memory port constants: widths, timing, reset values
// assumes inclusion by bare name from package and modules
`ifndef EMP_DEFINES_SVH
`define EMP_DEFINES_SVH
`define EMP_ADDR_W 18
`define EMP_DATA_W 24
`define EMP_ATTR_N 4
`define EMP_CLK_MHZ 40
`define EMP_BUS_CLOCK_OUT_LIMIT_MHZ 100
`define EMP_ADDR_RST 18'h00000
`define EMP_DATA_RST 24'h000000
`define EMP_ACK_LAT 1
`endif

/* common/emp_pkg.sv */
// external memory port types
// assumes emp_defines.svh on the include path
`include "emp_defines.svh"
package emp_pkg;
  typedef enum logic [2:0] {
    EMP_IDLE = 3'b001,
    EMP_BUSY = 3'b010,
    EMP_DONE = 3'b100
  } emp_state_e;
endpackage

/* verilog/emp_sync.sv */
// three-flop synchroniser with agreement of last two stages
// assumes a single clock and asynchronous active-low reset
`timescale 1ns/10ps
module emp_sync (
  input wire logic mclk_i, // core clock
  input wire logic rst_n_i, // async reset, low
  input wire logic async_i, // pin input
  output logic sync_o, // filtered level
  output logic rise_o, // one-cycle rise pulse
  output logic fall_o // one-cycle fall pulse
);
  logic [2:0] stg;
  logic [2:0] next_stg;
  logic lvl;
  logic next_lvl;
  // shift and accept when stages two and three agree
  always_comb begin
    next_stg = {stg[1:0], async_i};
    next_lvl = (stg[2] == stg[1]) ? stg[2] : lvl;
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stg <= 3'h0;
      lvl <= 1'b0;
    end else begin
      stg <= next_stg;
      lvl <= next_lvl;
    end
  end
  assign sync_o = lvl;
  assign rise_o = next_lvl & ~lvl;
  assign fall_o = ~next_lvl & lvl;
endmodule

/* verification/emp_mem_model.sv */
// external memory partner: selected by attribute line 0, acks after wait states
// assumes the bench resolves the data wire and computes the select
`timescale 1ns/10ps
`include "emp_defines.svh"
module emp_mem_model (
  input wire logic mclk_i, // core clock
  input wire logic [`EMP_ADDR_W-1:0] addr_i, // address wire
  input wire logic cs_i, // selected
  input wire logic wr_i, // device drives data
  input wire logic [`EMP_DATA_W-1:0] dq_i, // resolved data wire
  input wire logic [3:0] wait_i, // wait states before ack
  output logic [`EMP_DATA_W-1:0] dq_o = 24'h000000, // data toward device
  output logic ack_n_o = 1'b1 // ack, low active
);
  logic [`EMP_DATA_W-1:0] mem [logic [`EMP_ADDR_W-1:0]];
  int cnt = 0;
  // wait states, ack, store written word while acked
  always @(posedge mclk_i) begin
    cnt <= cs_i ? cnt + 1 : 0;
    ack_n_o <= !(cs_i && cnt >= int'(wait_i));
    if (cs_i && wr_i && !ack_n_o) mem[addr_i] = dq_i;
  end
  // stored word on read, else a pattern that keeps changing
  always @(negedge mclk_i) begin
    if (cs_i && !wr_i && mem.exists(addr_i)) dq_o <= mem[addr_i];
    else dq_o <= ~dq_o;
  end
endmodule

/* verification/test_external_memory_port_pins.sv */
// bench for the memory port pins against a reference memory model
// assumes 40 MHz core clock and 200 ns reference clock
`timescale 1ns/10ps
`include "emp_defines.svh"
module test_external_memory_port_pins import emp_pkg::*;;
  logic mclk_i = 0, rst_n_i = 0, owner = 0, stby = 0, pll_en = 0, unity = 0, refclk = 0;
  logic req = 0, wr = 0, a_oe, d_oe, t_oe, bclk, done, ack_n, cs;
  logic [17:0] addr = 18'h00000, a_o, a;
  logic [23:0] wdata = 24'h000000, d_o, d_i, m_d, rdata;
  logic [3:0] sel = 4'h1, ras = 4'h0, pol = 4'hF, attr, wt = 4'h1;
  logic [15:0] rnd = 16'h000B;
  logic [23:0] exp_mem [logic [17:0]];
  int mismatches = 0, n_checks = 0;
  // clocks, reference unrelated in phase
  always #12.5 mclk_i = ~mclk_i;
  initial begin
    #37;
    forever #100 refclk = ~refclk;
  end
  // select and data wire
  assign cs = (t_oe === 1'b0) && (attr[0] === pol[0]);
  assign d_i = (d_oe === 1'b0) ? d_o : m_d;
  emp_port dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_owner_i(owner), .standby_i(stby),
    .pll_en_i(pll_en), .pll_unity_i(unity), .ref_clock_in_i(refclk), .acc_req_i(req),
    .acc_wr_i(wr), .acc_addr_i(addr), .acc_wdata_i(wdata), .attr_sel_i(sel),
    .attr_ras_mode_i(ras), .attr_pol_i(pol), .transfer_ack_in_i(ack_n), .ext_data_in_i(d_i),
    .ext_addr_out_o(a_o), .ext_addr_oe_n_o(a_oe), .ext_data_out_o(d_o), .ext_data_oe_n_o(d_oe),
    .addr_attribute_lines_o(attr), .attr_oe_n_o(t_oe), .bus_clock_out_o(bclk),
    .acc_done_o(done), .acc_rdata_o(rdata));
  emp_mem_model mem_u (.mclk_i(mclk_i), .addr_i(a_o), .cs_i(cs), .wr_i(d_oe === 1'b0),
    .dq_i(d_i), .wait_i(wt), .dq_o(m_d), .ack_n_o(ack_n));
  // compare helpers
  task automatic chk(input logic [23:0] got, input logic [23:0] want, input string what);
    n_checks++;
    if (got !== want) begin
      mismatches++;
      $display("unexpected at %0t: %s %h not %h", $time, what, got, want);
    end
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // one access, checked against the bench's expected memory
  task automatic acc(input logic w, input logic [17:0] ad, input logic ok);
    logic [23:0] dat;
    int k;
    dat = {rnd, rnd[7:0]};
    rnd = lfsr(rnd);
    wr = w;
    addr = ad;
    wdata = dat;
    req = 1;
    cyc(1);
    req = 0;
    cyc(1);
    if (ok) chk(24'(a_o), 24'(ad), "address");
    if (ok) chk(24'(attr), {20'h00000, ~(sel ^ pol)}, "attribute");
    for (k = 0; k < 200 && done !== 1'b1; k++) cyc(1);
    chk(24'(done), 24'(ok), "done");
    if (ok && w) exp_mem[ad] = dat;
    if (ok && !w) chk(rdata, exp_mem[ad], "read data");
    cyc(3);
    if (ok) chk(24'({a_o, attr}), 24'({ad, ~pol}), "idle hold");
  endtask
  task automatic edges(input int want);
    int n;
    logic p;
    n = 0;
    p = bclk;
    repeat (160) begin
      cyc(1);
      if (bclk && !p) n++;
      p = bclk;
    end
    chk(24'(n >= want - 1 && n <= want + 1), 24'h000001, "bus clock rises");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    cyc(10);
    chk(24'({a_oe, d_oe, t_oe}), 24'h000007, "reset float");
    rst_n_i = 1;
    cyc(2);
    acc(1, 18'h00001, 0);
    chk(24'({a_oe, d_oe, t_oe}), 24'h000007, "no owner float");
    owner = 1;
    cyc(2);
    for (int i = 0; i < 8; i++) begin
      pol = rnd[3:0];
      ras = rnd[7:4];
      sel = {rnd[10:8], 1'b1};
      wt = {1'b0, rnd[13:11]};
      pll_en = i[1];
      unity = i[2];
      a = {i[1:0], rnd};
      rnd = lfsr(rnd);
      acc(1, a, 1);
      acc(0, a, 1);
    end
    pll_en = 0;
    unity = 0;
    edges(10);
    pll_en = 1;
    unity = 1;
    edges(20);
    stby = 1;
    cyc(3);
    chk(24'({a_oe, d_oe, t_oe}), 24'h000007, "standby float");
    acc(0, a, 0);
    stby = 0;
    wt = 4'hF;
    fork
      acc(0, a, 0);
      begin
        cyc(4);
        owner = 0;
      end
    join
    chk(24'({a_oe, d_oe, t_oe}), 24'h000007, "abort float");
    results;
  end
  // watchdog
  initial begin
    #2000000;
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    results;
  end
endmodule
